// ==== rtl/isd_slave.sv ====
// I2C slave with debug address, APB registers and receive buffer
//
// Function
// - With debug enabled, answer the debug ID address and flag debug.
// - With debug disabled, answer only the programmed slave address.
// - Address register: bit 7 enables slave, bits 6..0 hold address.
// - Debug and ordinary addressing work at the same time.
// - Receive: address match sets match flag, then shift in SDA bits.
// - Set receive flag whenever a full byte is ready to read.
// - Byte arrives with receive buffer full, no stretching: answer NACK.
// - Same with stretching: hold SCL low until software reads a byte from the buffer.
// - Transmit: on match set flag, load preloaded byte, shift it out.
// - Loading the transmit byte sets the transmit buffer flag.
// - Shifter empty, flag set, stretching on: hold SCL until new data.
// - Shifter empty, flag set, stretching off: resend old byte, NACK.
// - Master NACK ends the read; release SDA for STOP or restart.
// - Filter on: accept a new level after FILT_CYC samples; FILT_CYC is 1, so no spike on SDA or SCL is dropped.
// - Filter off: SDA and SCL pass without filtering.
// - Control bit 7 resets the state machine and clears the address.
// - Each interrupt enable except bit 7 (debug) gates its flag onto the slave interrupt.
`timescale 1ns/10ps
`default_nettype none
module isd_slave #(
   parameter int DEPTH = 2
) (
   input wire logic pclk, // Peripheral clock
   input wire logic presetn, // Async reset, active low
   input wire logic [7:0] paddr, // APB address
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error on unmapped address
   input wire logic scl_i, // SCL level on the wire
   output logic scl_o, // SCL drive value, always low
   output logic scl_oe, // SCL pulled low while high
   input wire logic sda_i, // SDA level on the wire
   output logic sda_o, // SDA drive value, always low
   output logic sda_oe, // SDA pulled low while high
   output logic irq, // Slave interrupt request
   output logic debug_irq // Debug address matched
);
   typedef enum logic [3:0] {
      ST_IDLE, ST_ADDR, ST_AACK, ST_RX, ST_RHOLD, ST_RACK,
      ST_TX, ST_TACK, ST_THOLD, ST_WAIT
   } isd_state_e;

   isd_state_e st_q;
   logic [7:0] ctrl_q, sadr_q, ien_q, dbg_q, stat_q, txd_q;
   logic [7:0] sh_q, txl_q;
   logic [3:0] bit_q;
   logic rw_q, mack_q, rnack_q, act_q;
   logic sda_oe_q, scl_oe_q, push_q, load_q;
   logic ev_dbg_q, ev_adr_q, ev_stop_q, ev_rs_q, ev_nack_q;
   logic [31:0] prdata_q;
   logic pready_q, pslverr_q, irq_q;
   logic [7:0] fifo_q [DEPTH];
   logic [$clog2(DEPTH)-1:0] wp_q, rp_q;
   logic [$clog2(DEPTH):0] cnt_q;
   logic raw [2];
   logic s1_q [2];
   logic s2_q [2];
   logic f_q [2];
   logic fp_q [2];
   logic [3:0] fc_q [2];
   logic setup, acc, wr, rd, srst, stren, full, scl_r, scl_f;
   logic start_c, stop_c;

   // Register select, used by read mux, error and write decode
   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      hit = (a == o);
   endfunction

   assign setup = psel & ~penable;
   assign acc = psel & penable & pready_q;
   assign wr = acc & pwrite;
   assign rd = acc & ~pwrite;
   assign srst = ctrl_q[isd_pkg::C_SRST];
   assign stren = ctrl_q[isd_pkg::C_STR];
   assign full = (cnt_q == ($clog2(DEPTH)+1)'(DEPTH));
   assign raw[0] = scl_i;
   assign raw[1] = sda_i;

   // Two-flop sync, then an optional stability filter per line
   for (genvar g = 0; g < 2; g++) begin : g_in
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            s1_q[g] <= 1'b1;
            s2_q[g] <= 1'b1;
            f_q[g] <= 1'b1;
            fp_q[g] <= 1'b1;
            fc_q[g] <= 4'h0;
         end else begin
            s1_q[g] <= raw[g];
            s2_q[g] <= s1_q[g];
            fp_q[g] <= f_q[g];
            if (!ctrl_q[isd_pkg::C_FILT]) begin
               f_q[g] <= s2_q[g];
               fc_q[g] <= 4'h0;
            end else if (s2_q[g] == f_q[g]) begin
               fc_q[g] <= 4'h0; // Glitch gone before it was accepted
            end else if (fc_q[g] == 4'(isd_pkg::FILT_CYC - 1)) begin
               f_q[g] <= s2_q[g];
               fc_q[g] <= 4'h0;
            end else begin
               fc_q[g] <= fc_q[g] + 4'h1;
            end
         end
      end
   end

   assign scl_r = f_q[0] & ~fp_q[0];
   assign scl_f = ~f_q[0] & fp_q[0];
   assign start_c = f_q[0] & fp_q[0] & ~f_q[1] & fp_q[1];
   assign stop_c = f_q[0] & fp_q[0] & f_q[1] & ~fp_q[1];

   // Bus protocol state machine; drives SDA and SCL low only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= ST_IDLE;
         sh_q <= 8'h00;
         txl_q <= 8'h00;
         bit_q <= 4'h0;
         {rw_q, mack_q, rnack_q, act_q} <= 4'h0;
         {sda_oe_q, scl_oe_q, push_q, load_q} <= 4'h0;
         {ev_dbg_q, ev_adr_q, ev_stop_q, ev_rs_q, ev_nack_q} <= 5'h00;
      end else begin
         {push_q, load_q} <= 2'b00;
         {ev_dbg_q, ev_adr_q, ev_stop_q, ev_rs_q, ev_nack_q} <= 5'h00;
         if (srst) begin
            st_q <= ST_IDLE;
            {sda_oe_q, scl_oe_q, act_q} <= 3'b000;
         end else if (stop_c) begin
            st_q <= ST_IDLE;
            ev_stop_q <= act_q;
            {sda_oe_q, scl_oe_q, act_q} <= 3'b000;
         end else if (start_c) begin
            st_q <= ST_ADDR;
            ev_rs_q <= act_q;
            bit_q <= 4'h0;
            {sda_oe_q, scl_oe_q} <= 2'b00;
         end else begin
            if (scl_r && bit_q < isd_pkg::BITS8) begin
               sh_q <= {sh_q[6:0], f_q[1]};
               bit_q <= bit_q + 4'h1;
            end
            if (scl_r && st_q == ST_TACK)
               mack_q <= ~f_q[1];
            case (st_q)
               ST_ADDR: if (scl_f && bit_q == isd_pkg::BITS8) begin
                  bit_q <= 4'h0;
                  rw_q <= sh_q[0];
                  if (dbg_q[isd_pkg::ADR_EN] &&
                      sh_q[7:1] == dbg_q[6:0]) begin
                     ev_dbg_q <= 1'b1;
                     ev_adr_q <= 1'b1;
                     act_q <= 1'b1;
                     sda_oe_q <= 1'b1;
                     st_q <= ST_AACK;
                  end else if (sadr_q[isd_pkg::ADR_EN] &&
                      sh_q[7:1] == sadr_q[6:0]) begin
                     ev_adr_q <= 1'b1;
                     act_q <= 1'b1;
                     sda_oe_q <= 1'b1;
                     st_q <= ST_AACK;
                  end else begin
                     st_q <= ST_WAIT;
                  end
               end
               ST_AACK: if (scl_f) begin
                  sda_oe_q <= 1'b0;
                  bit_q <= 4'h0; // The ack clock is not a data bit
                  st_q <= rw_q ? ST_TACK : ST_RX;
                  mack_q <= 1'b1; // Address phase counts as acknowledged
               end
               ST_RX: if (scl_f && bit_q == isd_pkg::BITS8) begin
                  bit_q <= 4'h0;
                  rnack_q <= 1'b0;
                  if (!full) begin
                     push_q <= 1'b1;
                     sda_oe_q <= 1'b1;
                     st_q <= ST_RACK;
                  end else if (stren) begin
                     scl_oe_q <= 1'b1;
                     st_q <= ST_RHOLD;
                  end else begin
                     rnack_q <= 1'b1;
                     st_q <= ST_RACK;
                  end
               end
               ST_RHOLD: if (!full) begin
                  push_q <= 1'b1;
                  sda_oe_q <= 1'b1;
                  scl_oe_q <= 1'b0;
                  st_q <= ST_RACK;
               end
               ST_RACK: if (scl_f) begin
                  sda_oe_q <= 1'b0;
                  bit_q <= 4'h0; // Next byte counts from zero
                  st_q <= ST_RX;
               end
               ST_TACK: if (scl_f || (bit_q == 4'h0 && mack_q &&
                            rw_q && sda_oe_q == 1'b0 && act_q &&
                            f_q[0] == 1'b0 && fp_q[0] == 1'b0)) begin
                  bit_q <= 4'h0;
                  if (!mack_q) begin
                     sda_oe_q <= 1'b0;
                     st_q <= ST_WAIT;
                  end else if (!stat_q[isd_pkg::S_TXB]) begin
                     sh_q <= txd_q;
                     txl_q <= txd_q;
                     load_q <= 1'b1;
                     sda_oe_q <= ~txd_q[7];
                     st_q <= ST_TX;
                  end else if (stren) begin
                     scl_oe_q <= 1'b1;
                     st_q <= ST_THOLD;
                  end else begin
                     sh_q <= txl_q;
                     ev_nack_q <= 1'b1;
                     sda_oe_q <= ~txl_q[7];
                     st_q <= ST_TX;
                  end
               end
               ST_THOLD: if (!stat_q[isd_pkg::S_TXB]) begin
                  sh_q <= txd_q;
                  txl_q <= txd_q;
                  load_q <= 1'b1;
                  sda_oe_q <= ~txd_q[7];
                  scl_oe_q <= 1'b0;
                  st_q <= ST_TX;
               end
               ST_TX: if (scl_f) begin
                  if (bit_q == isd_pkg::BITS8) begin
                     sda_oe_q <= 1'b0;
                     mack_q <= 1'b0; // Wait for the master's own answer
                     bit_q <= 4'h0;
                     st_q <= ST_TACK;
                  end else begin
                     sda_oe_q <= ~sh_q[7];
                  end
               end
               ST_IDLE, ST_WAIT: sda_oe_q <= 1'b0;
               default: st_q <= ST_IDLE;
            endcase
         end
      end
   end

   // Receive buffer; a full buffer stalls the protocol machine when stretching is on
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push_q && !full) begin
            fifo_q[wp_q] <= sh_q;
            wp_q <= wp_q + 1'b1;
         end
         if (rd && hit(paddr, isd_pkg::A_DATA) && cnt_q != '0)
            rp_q <= rp_q + 1'b1;
         cnt_q <= cnt_q + ($clog2(DEPTH)+1)'(push_q && !full)
            - ($clog2(DEPTH)+1)'(rd && hit(paddr, isd_pkg::A_DATA)
            && cnt_q != '0);
      end
   end

   // Software registers; soft reset clears the slave address
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {ctrl_q, sadr_q, ien_q, dbg_q, txd_q} <= {5{isd_pkg::RST8}};
      end else begin
         if (wr && hit(paddr, isd_pkg::A_CTRL)) ctrl_q <= pwdata[7:0];
         if (srst) sadr_q <= isd_pkg::RST8;
         else if (wr && hit(paddr, isd_pkg::A_SADR)) sadr_q <= pwdata[7:0];
         if (wr && hit(paddr, isd_pkg::A_IEN)) ien_q <= pwdata[7:0];
         if (wr && hit(paddr, isd_pkg::A_DBG)) dbg_q <= pwdata[7:0];
         if (wr && hit(paddr, isd_pkg::A_DATA)) txd_q <= pwdata[7:0];
      end
   end

   // Sticky flags; a hardware set wins over a software clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat_q <= isd_pkg::RST8;
      end else begin
         stat_q <= (stat_q & ~((wr && hit(paddr, isd_pkg::A_STAT))
            ? (pwdata[7:0] & isd_pkg::W1C_MASK) : 8'h00))
            | {ev_dbg_q, ev_adr_q, ev_stop_q, ev_rs_q, 4'h0}
            | {7'h00, ev_nack_q};
         if (load_q) stat_q[isd_pkg::S_TXB] <= 1'b1;
         else if (wr && hit(paddr, isd_pkg::A_DATA))
            stat_q[isd_pkg::S_TXB] <= 1'b0;
         stat_q[isd_pkg::S_RCB] <= (cnt_q != '0);
      end
   end

   // APB answer with no wait state; slave interrupt output
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= '0;
         {pready_q, pslverr_q, irq_q} <= 3'b000;
      end else begin
         pready_q <= setup;
         pslverr_q <= setup && !(hit(paddr, isd_pkg::A_CTRL) ||
            hit(paddr, isd_pkg::A_SADR) || hit(paddr, isd_pkg::A_DATA) ||
            hit(paddr, isd_pkg::A_STAT) || hit(paddr, isd_pkg::A_IEN) ||
            hit(paddr, isd_pkg::A_DBG));
         prdata_q <= '0;
         if (setup && hit(paddr, isd_pkg::A_CTRL))
            prdata_q[isd_pkg::C_XMT] <= (st_q == ST_TX || st_q == ST_TACK
               || st_q == ST_THOLD);
         if (setup && hit(paddr, isd_pkg::A_SADR)) prdata_q[7:0] <= sadr_q;
         if (setup && hit(paddr, isd_pkg::A_DATA))
            prdata_q[7:0] <= fifo_q[rp_q];
         if (setup && hit(paddr, isd_pkg::A_STAT)) prdata_q[7:0] <= stat_q;
         if (setup && hit(paddr, isd_pkg::A_IEN)) prdata_q[7:0] <= ien_q;
         if (setup && hit(paddr, isd_pkg::A_DBG)) prdata_q[7:0] <= dbg_q;
         irq_q <= |(stat_q & ien_q & ~8'h80);
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign scl_o = 1'b0;
   assign sda_o = 1'b0;
   assign scl_oe = scl_oe_q;
   assign sda_oe = sda_oe_q;
   assign irq = irq_q;
   assign debug_irq = stat_q[isd_pkg::S_DBG];

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   rx_stretch_a: assert property (st_q == ST_RHOLD |-> scl_oe_q)
      else $error("receive stall without SCL hold");
   rx_nack_a: assert property (
      st_q == ST_RX && scl_f && bit_q == isd_pkg::BITS8 && full && !stren
      && !srst && !stop_c && !start_c |=> st_q == ST_RACK && !sda_oe_q)
      else $error("overrun byte was acknowledged");
   rx_nack_hold_a: assert property (
      st_q == ST_RACK && rnack_q |-> !sda_oe_q)
      else $error("refused byte was acknowledged");
   tx_stretch_a: assert property (st_q == ST_THOLD |-> scl_oe_q)
      else $error("transmit stall without SCL hold");
   mnack_rel_a: assert property (st_q == ST_WAIT |=> !sda_oe_q)
      else $error("SDA held after master NACK");
   srst_a: assert property (srst |=> sadr_q == 8'h00 && st_q == ST_IDLE)
      else $error("soft reset did not clear");
   txb_set_a: assert property (load_q |=> stat_q[isd_pkg::S_TXB])
      else $error("transmit flag not set on load");
   rcb_a: assert property (push_q && !full |=> ##1 stat_q[isd_pkg::S_RCB])
      else $error("receive flag missing");
   filt_off_a: assert property (!ctrl_q[isd_pkg::C_FILT]
      && !$past(ctrl_q[isd_pkg::C_FILT]) |-> f_q[1] == $past(s2_q[1]))
      else $error("unfiltered SDA lagged");
   irq_a: assert property (ien_q == 8'h00 |=> !irq_q)
      else $error("interrupt with all enables off");
endmodule
`default_nettype wire

// ==== shared/isd_pkg.sv ====
// Constants shared by the I2C slave and debug port block
package isd_pkg;
   // Clock and spike filter timing
   localparam int CLK_NS = 10;
   localparam int FILT_NS = 5;
   localparam int FILT_RAW = (FILT_NS + CLK_NS - 1) / CLK_NS;
   localparam int FILT_CYC = (FILT_RAW < 1) ? 1 : FILT_RAW;
   // Register byte addresses
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_SADR = 8'h04;
   localparam logic [7:0] A_DATA = 8'h08;
   localparam logic [7:0] A_STAT = 8'h0c;
   localparam logic [7:0] A_IEN = 8'h10;
   localparam logic [7:0] A_DBG = 8'h14;
   // Control bits (write side) and transmitting status (read side)
   localparam int C_SRST = 7;
   localparam int C_STR = 6;
   localparam int C_FILT = 5;
   localparam int C_XMT = 0;
   // Address register enable bit, also debug port enable in A_DBG
   localparam int ADR_EN = 7;
   // Status and interrupt enable bit positions
   localparam int S_DBG = 7;
   localparam int S_ADDR = 6;
   localparam int S_STOP = 5;
   localparam int S_RSTRT = 4;
   localparam int S_TXB = 3;
   localparam int S_RCB = 2;
   localparam int S_NACK = 0;
   // Status bits cleared by writing one
   localparam logic [7:0] W1C_MASK = 8'hf1;
   localparam logic [7:0] RST8 = 8'h00;
   localparam logic [3:0] BITS8 = 4'h8;
endpackage

// ==== dv/isd_i2c_master.sv ====
// Behavioural I2C master for the slave and debug port bench
`timescale 1ns/10ps
`default_nettype none
module isd_i2c_master (
   input wire logic scl, // SCL wire level
   input wire logic sda, // SDA wire level
   output logic scl_oe, // Pulls SCL low while high
   output logic sda_oe // Pulls SDA low while high
);
   int stalls = 0; // Time steps lost to stretching
   // Lines start released; SCL stands still outside frames
   initial begin
      scl_oe = 1'b0;
      sda_oe = 1'b0;
   end
   // One bit: SDA set early in the low phase, read late in the high phase;
   // a held SCL keeps the master waiting, so it is no kinder than a host
   task automatic bit_io(input logic b, output logic r);
      #10 sda_oe = !b;
      #40 scl_oe = 1'b0;
      while (scl !== 1'b1) begin
         #10 stalls++;
      end
      #28 r = sda;
      #2 scl_oe = 1'b1;
   endtask
   // Start from idle: SDA falls while SCL is high
   task automatic start();
      sda_oe = 1'b0;
      scl_oe = 1'b0;
      #40 sda_oe = 1'b1;
      #40 scl_oe = 1'b1;
   endtask
   // Stop: SDA rises while SCL is high, then both rest released
   task automatic stop();
      #10 sda_oe = 1'b1;
      #40 scl_oe = 1'b0;
      #40 sda_oe = 1'b0;
      #40;
   endtask
   // Eight bits MSB first, then the ninth; ack_out is its line level
   task automatic xfer(input logic [7:0] tx, input logic ack_in,
                       output logic [7:0] rx, output logic ack_out);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(tx[i], r);
         rx[i] = r;
      end
      bit_io(ack_in, ack_out); // Master NACK ends a read
   endtask
endmodule
`default_nettype wire

// ==== dv/test_isd_slave.sv ====
// Self-checking bench for the I2C slave and debug port block
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin \
mismatches++; $display("wrong value at %0t: %h not %h", $time, got, exp); \
end end
module test_isd_slave;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic scl_oe, sda_oe, m_scl, m_sda, irq, debug_irq, ack;
   wire logic scl_w, sda_w, scl_o, sda_o;
   logic [7:0] rx, d1, d2, d3, x, y;
   logic [6:0] sa, db;
   logic [31:0] seed = 32'h4d;
   logic [63:0] expq[$];
   int checks = 0;
   int mismatches = 0;
   int cyc = 0;
   // Open-drain wires with pull-ups
   assign scl_w = (scl_oe | m_scl) ? 1'b0 : 1'b1;
   assign sda_w = (sda_oe | m_sda) ? 1'b0 : 1'b1;
   isd_slave #(.DEPTH(2)) uut (.pclk(pclk), .presetn(presetn),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe),
      .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .irq(irq),
      .debug_irq(debug_irq));
   isd_i2c_master m (.scl(scl_w), .sda(sda_w), .scl_oe(m_scl),
      .sda_oe(m_sda));
   always #5 pclk = !pclk;
   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Bus master; a read notes {mask, expected} for the watcher
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [31:0] msk);
      if (!w) expq.push_back({msk, d});
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= w ? d : 32'h0;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Read results are compared here as they appear on the bus
   always @(posedge pclk) begin
      logic [63:0] e;
      if (psel && penable && pready === 1'b1 && !pwrite && expq.size()) begin
         e = expq.pop_front();
         `CHK(prdata & e[63:32], e[31:0])
      end
   end
   // Cut a hang short
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         report_and_stop();
      end
   end
   // Address-only frame
   task automatic frame(input logic [6:0] a, input logic rd_bit);
      m.start();
      m.xfer({a, rd_bit}, 1'b1, rx, ack);
      m.stop();
   endtask
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      // Reset values and the unmapped slot
      apb(0, isd_pkg::A_CTRL, 32'h0, 32'hffffffff);
      apb(0, isd_pkg::A_SADR, 32'h0, 32'hffffffff);
      apb(0, isd_pkg::A_STAT, 32'h0, 32'hffffffff);
      apb(0, isd_pkg::A_IEN, 32'h0, 32'hffffffff);
      apb(0, isd_pkg::A_DBG, 32'h0, 32'hffffffff);
      apb(0, 8'h18, 32'h0, 32'hffffffff);
      `CHK(err, 1'b1)
      $display("test reset done");
      // Receive until the two-entry buffer refuses
      sa = 7'(rnd());
      db = sa ^ 7'h01;
      d1 = rnd();
      d2 = rnd();
      d3 = rnd();
      apb(1, isd_pkg::A_SADR, {24'h0, 1'b1, sa}, 0);
      apb(1, isd_pkg::A_IEN, 32'h04, 0);
      m.start();
      m.xfer({sa, 1'b0}, 1'b1, rx, ack);
      `CHK(ack, 1'b0)
      m.xfer(d1, 1'b1, rx, ack);
      `CHK(irq, 1'b1)
      m.xfer(d2, 1'b1, rx, ack);
      `CHK(ack, 1'b0)
      m.xfer(d3, 1'b1, rx, ack);
      `CHK(ack, 1'b1)
      m.stop();
      apb(0, isd_pkg::A_STAT, 32'h64, 32'h64);
      apb(0, isd_pkg::A_DATA, d1, 32'hff);
      apb(0, isd_pkg::A_DATA, d2, 32'hff);
      apb(1, isd_pkg::A_IEN, 32'h0, 0);
      repeat (3) @(posedge pclk);
      `CHK(irq, 1'b0)
      $display("test receive done");
      // Debug address beside the ordinary one, then disabled
      apb(1, isd_pkg::A_STAT, 32'hff, 0);
      apb(1, isd_pkg::A_DBG, {24'h0, 1'b1, db}, 0);
      frame(db, 1'b0);
      `CHK(ack, 1'b0)
      `CHK(debug_irq, 1'b1)
      frame(sa, 1'b0);
      `CHK(ack, 1'b0)
      apb(1, isd_pkg::A_DBG, {24'h0, 1'b0, db}, 0);
      apb(1, isd_pkg::A_STAT, 32'hff, 0);
      frame(db, 1'b0);
      `CHK(ack, 1'b1)
      `CHK(debug_irq, 1'b0)
      $display("test debug done");
      // Transmit without stretching: stale byte is sent again
      x = rnd() & 8'h7f; // Low MSB, so a wrong resend shows on SDA
      apb(1, isd_pkg::A_DATA, {24'h0, x}, 0);
      m.start();
      m.xfer({sa, 1'b1}, 1'b1, rx, ack);
      `CHK(ack, 1'b0)
      m.xfer(8'hff, 1'b0, rx, ack);
      `CHK(rx, x)
      apb(0, isd_pkg::A_STAT, 32'h48, 32'h48);
      m.xfer(8'hff, 1'b1, rx, ack);
      `CHK(rx, x)
      #100 `CHK(sda_oe, 1'b0)
      m.stop();
      apb(0, isd_pkg::A_STAT, 32'h01, 32'h01);
      $display("test transmit done");
      // Stretching on both directions while software is late
      apb(1, isd_pkg::A_STAT, 32'hff, 0);
      apb(1, isd_pkg::A_CTRL, 32'h40, 0);
      m.start();
      m.xfer({sa, 1'b0}, 1'b1, rx, ack);
      m.xfer(d1, 1'b1, rx, ack);
      m.xfer(d2, 1'b1, rx, ack);
      fork
         m.xfer(d3, 1'b1, rx, ack);
         begin
            #1500 `CHK({scl_o, sda_o, scl_oe}, 3'b001)
            apb(0, isd_pkg::A_DATA, d1, 32'hff);
         end
      join
      `CHK(ack, 1'b0)
      m.stop();
      apb(0, isd_pkg::A_DATA, d2, 32'hff);
      apb(0, isd_pkg::A_DATA, d3, 32'hff);
      x = rnd();
      y = rnd();
      apb(1, isd_pkg::A_DATA, {24'h0, x}, 0);
      m.start();
      m.xfer({sa, 1'b1}, 1'b1, rx, ack);
      m.xfer(8'hff, 1'b0, rx, ack);
      `CHK(rx, x)
      fork
         m.xfer(8'hff, 1'b1, rx, ack);
         begin
            #1500 `CHK(scl_oe, 1'b1)
            apb(0, isd_pkg::A_CTRL, 32'h1, 32'hff);
            apb(1, isd_pkg::A_DATA, {24'h0, y}, 0);
         end
      join
      `CHK(rx, y)
      m.stop();
      $display("test stretch done");
      // Soft reset clears the address and silences the slave
      apb(1, isd_pkg::A_CTRL, 32'h80, 0);
      apb(0, isd_pkg::A_SADR, 32'h0, 32'hff);
      apb(1, isd_pkg::A_CTRL, 32'h20, 0);
      frame(sa, 1'b0);
      `CHK(ack, 1'b1)
      apb(1, isd_pkg::A_SADR, {24'h0, 1'b1, sa}, 0);
      frame(sa, 1'b0);
      `CHK(ack, 1'b0)
      $display("test soft reset done");
      report_and_stop();
   end
endmodule
`default_nettype wire
